// *** rtl/stop_recovery_pkg.sv ***
// Constants, types and register layout for the stop recovery and reset cause block.
// Assumes a 100 MHz core clock and an APB slave with 32-bit data.
package stop_recovery_pkg;

  localparam logic [11:0] ADDR_CAUSE  = 12'hFF0;
  localparam logic [11:0] ADDR_OSC    = 12'hFF4;
  localparam logic [11:0] ADDR_LOWSUP = 12'hFF8;
  localparam logic [11:0] ADDR_STATUS = 12'hFFC;

  localparam int BIT_POWERUP  = 7;
  localparam int BIT_STOPWAKE = 6;
  localparam int BIT_DOG      = 5;
  localparam int BIT_PINRST   = 4;
  localparam int BIT_LOWSUP   = 0;

  localparam logic [7:0] DOG_CTL_RESET = 8'h00;
  localparam logic [7:0] OSC_CTL_RESET = 8'hA0;
  localparam logic [7:0] OSC_IPO_ON    = 8'h80;
  localparam logic [7:0] OSC_SEL_MASK  = 8'h03;

  localparam int OSC_BIT_XTAL = 5;
  localparam int LOWSUP_BIT_IEN = 0;
  localparam int LOWSUP_BIT_BOD = 1;

  localparam int         PORT_W         = 8;
  localparam int         HOLD_SHORT_CYC = 66;
  localparam int         HOLD_LONG_CYC  = 5000;
  localparam logic [12:0] HOLD_SHORT    = 13'(HOLD_SHORT_CYC);
  localparam logic [12:0] HOLD_LONG     = 13'(HOLD_LONG_CYC);

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_STOP = 2'b01,
    ST_HOLD = 2'b11,
    ST_DONE = 2'b10
  } phase_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic powerUp;
    logic stopWake;
    logic dogFlag;
    logic pinReset;
  } cause_type;

endpackage

// *** rtl/wake_hold_counter.sv ***
// Hold-in-reset counter for stop wake.
// Assumes it is clocked from the internal oscillator domain clock.
`timescale 1ns/100ps
module wake_hold_counter (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic        xtalOn,
  output logic             busy,
  output logic             done
);
  typedef struct packed {
    logic [12:0] count;
    logic        busy;
    logic        done;
  } state_type;

  state_type stateQ;
  state_type stateD;

  always_comb begin
    stateD      = stateQ;
    stateD.done = 1'b0;
    if (start && !stateQ.busy) begin
      // length picked by crystal enable
      stateD.count = xtalOn ? stop_recovery_pkg::HOLD_LONG : stop_recovery_pkg::HOLD_SHORT;
      stateD.busy  = 1'b1;
    end else if (stateQ.busy) begin
      stateD.count = stateQ.count - 13'h0001;
      if (stateQ.count == 13'h0001) begin
        stateD.busy = 1'b0;
        stateD.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  assign busy = stateQ.busy;
  assign done = stateQ.done;
endmodule

// *** rtl/pin_change_detect.sv ***
// Per-pin change detect for enabled wake pins, with frozen input capture.
// Assumes pins already synchronous to core_clk.
`timescale 1ns/100ps
module pin_change_detect (
  input  wire logic                                 core_clk,
  input  wire logic                                 sys_rst,
  input  wire logic [stop_recovery_pkg::PORT_W-1:0] pins,
  input  wire logic [stop_recovery_pkg::PORT_W-1:0] wakeEnable,
  input  wire logic                                 frozen,
  output logic                                      change,
  output logic      [stop_recovery_pkg::PORT_W-1:0] portInput
);
  typedef struct packed {
    logic [stop_recovery_pkg::PORT_W-1:0] held;
  } state_type;

  state_type                            stateQ;
  state_type                            stateD;
  logic [stop_recovery_pkg::PORT_W-1:0] diff;

  genvar i;
  generate
    for (i = 0; i < stop_recovery_pkg::PORT_W; i = i + 1) begin : g_pin
      // either direction counts
      assign diff[i] = wakeEnable[i] & (pins[i] ^ stateQ.held[i]);
    end
  endgenerate

  always_comb begin
    stateD = stateQ;
    if (!frozen) begin
      stateD.held = pins;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  assign change    = frozen & (|diff);
  assign portInput = stateQ.held;
endmodule

// *** rtl/stop_recovery_reset_status.sv ***
// Stop-mode wake sequencer with reset cause register on APB.
// Assumes synchronous pins, a pre-filtered reset pin level and a core that
// fetches its vector itself when coreReset falls.
`timescale 1ns/100ps
module stop_recovery_reset_status (
  input  wire logic                                 core_clk,
  input  wire logic                                 sys_rst,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [11:0]                          paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 stopEnter,
  input  wire logic                                 powerUpEvent,
  input  wire logic                                 debuggerReset,
  input  wire logic                                 dogTimeout,
  input  wire logic                                 dogResetSelect,
  input  wire logic                                 interruptsOn,
  input  wire logic                                 pinResetFiltered_n,
  input  wire logic                                 debugPin_n,
  input  wire logic                                 supplyLow,
  input  wire logic [stop_recovery_pkg::PORT_W-1:0] portPins,
  input  wire logic [stop_recovery_pkg::PORT_W-1:0] wakeEnable,
  output logic      [stop_recovery_pkg::PORT_W-1:0] portInput,
  output logic                                      coreReset,
  output logic                                      systemReset,
  output logic                                      oscEnable,
  output logic      [1:0]                           clockSelect,
  output logic                                      dogIrq,
  output logic                                      lowSupplyIrq,
  output logic      [7:0]                           dogControl
);

  typedef struct packed {
    stop_recovery_pkg::phase_type   phase;
    stop_recovery_pkg::cause_type   cause;
    logic [7:0]                     dogCtl;
    logic [7:0]                     osc_control_reg;
    logic [1:0]                     lowSupCtl;
    logic                           dogWake;
    logic                           irqPend;
    logic                           coreReset;
    logic                           systemReset;
    logic                           dogIrq;
    logic                           lowIrq;
    logic                           lowFlag;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    logic [stop_recovery_pkg::PORT_W-1:0] portIn;
  } state_type;

  state_type                            stateQ;
  state_type                            stateD;
  logic                                 pinChange;
  logic [stop_recovery_pkg::PORT_W-1:0] portNow;
  logic                                 holdBusy;
  logic                                 holdDone;
  logic                                 wakeReq;
  logic                                 inStop;
  logic                                 fullReset;
  logic                                 setup;
  logic                                 access;
  logic                                 lowDetect;
  logic                                 dogWakeNow;
  logic                                 dogRun;

  assign inStop     = (stateQ.phase == stop_recovery_pkg::ST_STOP);
  assign fullReset  = inStop & (!pinResetFiltered_n | !debugPin_n);
  assign dogWakeNow = inStop & dogTimeout;
  assign wakeReq    = !fullReset & (dogWakeNow | pinChange);
  assign dogRun     = dogTimeout & !inStop;
  assign setup      = psel & !penable;
  assign access     = psel & penable;
  assign lowDetect  = supplyLow & !stateQ.lowSupCtl[stop_recovery_pkg::LOWSUP_BIT_BOD];

  pin_change_detect u_pins (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .pins       (portPins),
    .wakeEnable (wakeEnable),
    .frozen     (inStop | holdBusy),
    .change     (pinChange),
    .portInput  (portNow)
  );

  wake_hold_counter u_hold (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (wakeReq),
    .xtalOn   (stateQ.osc_control_reg[stop_recovery_pkg::OSC_BIT_XTAL]),
    .busy     (holdBusy),
    .done     (holdDone)
  );

  always_comb begin
    stateD             = stateQ;
    stateD.pready      = 1'b0;
    stateD.pslverr     = 1'b0;
    stateD.systemReset = 1'b0;
    stateD.dogIrq      = 1'b0;
    stateD.portIn      = portNow;
    stateD.lowFlag     = lowDetect;
    stateD.lowIrq      = lowDetect & stateQ.lowSupCtl[stop_recovery_pkg::LOWSUP_BIT_IEN];

    // read returns the old bits, then clears them; events below win over the clear
    if (access && !stateQ.pready && !pwrite && paddr == stop_recovery_pkg::ADDR_CAUSE) begin
      stateD.cause = '0;
    end

    case (stateQ.phase)
      stop_recovery_pkg::ST_RUN: begin
        if (stopEnter) begin
          stateD.phase = stop_recovery_pkg::ST_STOP;
        end
        if (dogRun) begin
          stateD.cause.stopWake = 1'b0;
          stateD.cause.powerUp  = 1'b0;
          if (dogResetSelect) begin
            stateD.systemReset   = 1'b1;
            stateD.cause         = '0;
            stateD.cause.dogFlag = 1'b1;
          end else begin
            stateD.dogIrq        = interruptsOn;
            stateD.cause.dogFlag = 1'b1;
          end
        end
      end
      stop_recovery_pkg::ST_STOP: begin
        if (fullReset) begin
          stateD.systemReset = 1'b1;
          stateD.phase       = stop_recovery_pkg::ST_RUN;
          stateD.cause       = '0;
          if (!debugPin_n) begin
            stateD.cause.powerUp  = 1'b1;
          end else begin
            stateD.cause.pinReset = 1'b1;
          end
        end else if (wakeReq) begin
          stateD.phase     = stop_recovery_pkg::ST_HOLD;
          stateD.coreReset = 1'b1;
          stateD.dogWake   = dogWakeNow;
          stateD.irqPend   = dogWakeNow & !dogResetSelect & interruptsOn;
          // only oscillator and dog control change
          stateD.osc_control_reg    = (stateQ.osc_control_reg & ~stop_recovery_pkg::OSC_SEL_MASK)
                             | stop_recovery_pkg::OSC_IPO_ON;
          stateD.dogCtl    = stop_recovery_pkg::DOG_CTL_RESET;
        end
      end
      stop_recovery_pkg::ST_HOLD: begin
        if (holdDone) begin
          stateD.phase          = stop_recovery_pkg::ST_DONE;
          stateD.coreReset      = 1'b0;
          stateD.cause.stopWake = 1'b1;
          stateD.cause.powerUp  = 1'b0;
          if (stateQ.dogWake) begin
            stateD.cause.dogFlag = 1'b1;
          end else begin
            stateD.cause.dogFlag  = 1'b0;
            stateD.cause.pinReset = 1'b0;
          end
        end
      end
      stop_recovery_pkg::ST_DONE: begin
        stateD.phase   = stop_recovery_pkg::ST_RUN;
        stateD.dogIrq  = stateQ.irqPend;
        stateD.irqPend = 1'b0;
      end
      default: begin
        stateD.phase = stop_recovery_pkg::ST_RUN;
      end
    endcase

    if (powerUpEvent || debuggerReset) begin
      stateD.cause         = '0;
      stateD.cause.powerUp = 1'b1;
      stateD.phase         = stop_recovery_pkg::ST_RUN;
      stateD.coreReset     = 1'b0;
    end

    if (access && !stateQ.pready) begin
      stateD.pready = 1'b1;
      if (pwrite) begin
        case (paddr)
          stop_recovery_pkg::ADDR_CAUSE:  stateD.dogCtl    = pwdata[7:0];
          stop_recovery_pkg::ADDR_OSC:    stateD.osc_control_reg    = pwdata[7:0];
          stop_recovery_pkg::ADDR_LOWSUP: stateD.lowSupCtl = pwdata[1:0];
          stop_recovery_pkg::ADDR_STATUS: stateD.pslverr   = 1'b0;
          default:                        stateD.pslverr   = 1'b1;
        endcase
        stateD.prdata = 32'h0000_0000;
      end else begin
        case (paddr)
          stop_recovery_pkg::ADDR_CAUSE:
            stateD.prdata = {24'h000000, stateQ.cause.powerUp, stateQ.cause.stopWake,
                             stateQ.cause.dogFlag, stateQ.cause.pinReset, 3'h0,
                             stateQ.lowFlag};
          stop_recovery_pkg::ADDR_OSC:
            stateD.prdata = {24'h000000, stateQ.osc_control_reg};
          stop_recovery_pkg::ADDR_LOWSUP:
            stateD.prdata = {30'h00000000, stateQ.lowSupCtl};
          stop_recovery_pkg::ADDR_STATUS:
            stateD.prdata = {29'h00000000, stateQ.phase, stateQ.coreReset};
          default: begin
            stateD.prdata  = 32'h0000_0000;
            stateD.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ               <= '0;
      stateQ.phase         <= stop_recovery_pkg::ST_RUN;
      stateQ.cause.powerUp <= 1'b1;
      stateQ.dogCtl        <= stop_recovery_pkg::DOG_CTL_RESET;
      stateQ.osc_control_reg        <= stop_recovery_pkg::OSC_CTL_RESET;
    end else begin
      stateQ <= stateD;
    end
  end

  assign prdata       = stateQ.prdata;
  assign pready       = stateQ.pready;
  assign pslverr      = stateQ.pslverr;
  assign portInput    = stateQ.portIn;
  assign coreReset    = stateQ.coreReset;
  assign systemReset  = stateQ.systemReset;
  assign oscEnable    = stateQ.osc_control_reg[7];
  assign clockSelect  = stateQ.osc_control_reg[1:0];
  assign dogIrq       = stateQ.dogIrq;
  assign lowSupplyIrq = stateQ.lowIrq;
  assign dogControl   = stateQ.dogCtl;

  sequence wakeStart;
    inStop && wakeReq && !powerUpEvent && !debuggerReset;
  endsequence

  a_wake_holds_core: assert property (@(posedge core_clk) disable iff (sys_rst)
    wakeStart |=> coreReset)
    else $error("core not held after wake");
  a_wake_sets_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(coreReset) && !$past(powerUpEvent) |-> stateQ.cause.stopWake)
    else $error("stop-wake bit not set");
  a_wake_selects_ipo: assert property (@(posedge core_clk) disable iff (sys_rst)
    wakeStart |=> oscEnable && clockSelect == 2'b00)
    else $error("oscillator not selected");
  a_stop_dog_noreset: assert property (@(posedge core_clk) disable iff (sys_rst)
    inStop && dogTimeout && !fullReset |=> !systemReset)
    else $error("dog reset in stop");
  a_pin_full_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    fullReset && !powerUpEvent && !debuggerReset |=> systemReset)
    else $error("pin reset missed");
  a_low_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 stateQ.lowFlag == $past(lowDetect))
    else $error("low flag lags");
  a_bod_gates_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    stateQ.lowSupCtl[stop_recovery_pkg::LOWSUP_BIT_BOD] |=> !lowSupplyIrq)
    else $error("low irq while detector off");
  a_read_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    access && !pready && !pwrite && paddr == stop_recovery_pkg::ADDR_CAUSE
      && stateQ.phase == stop_recovery_pkg::ST_RUN && !dogTimeout
      && !powerUpEvent && !debuggerReset |=> stateQ.cause == '0)
    else $error("read did not clear");
  a_dog_irq_after: assert property (@(posedge core_clk) disable iff (sys_rst)
    inStop |-> !dogIrq)
    else $error("dog irq during stop");
endmodule

// *** testbench/core_partner.sv ***
// Behavioural core model: issues stop, times the wake hold, logs the vector fetch.
// Assumes coreReset and dogIrq come straight from the sequencer.
`timescale 1ns/100ps
module core_partner (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        stopRequest,
  input  wire logic        coreReset,
  input  wire logic        dogIrq,
  output logic             stopEnter,
  output logic      [15:0] holdLen_q,
  output logic      [15:0] fetchAddr_q,
  output logic      [7:0]  wakes_q,
  output logic      [7:0]  irqs_q,
  output logic             irqEarly_q
);
  logic [15:0] run_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stopEnter <= 1'b0;
      run_q <= 16'h0000;
      holdLen_q <= 16'h0000;
      fetchAddr_q <= 16'h0000;
      wakes_q <= 8'h00;
      irqs_q <= 8'h00;
      irqEarly_q <= 1'b0;
    end else begin
      stopEnter <= stopRequest;
      run_q <= coreReset ? run_q + 16'h0001 : 16'h0000;
      if (!coreReset && run_q != 16'h0000) begin
        holdLen_q <= run_q;
        fetchAddr_q <= 16'h0002;
        wakes_q <= wakes_q + 8'h01;
      end
      // every dogIrq cycle counts, even while coreReset holds the core; that case also sets irqEarly_q
      if (dogIrq) irqs_q <= irqs_q + 8'h01;
      if (dogIrq && coreReset) irqEarly_q <= 1'b1;
    end
  end
endmodule

// *** testbench/stop_recovery_reset_status_test.sv ***
// Self-checking bench for the stop recovery sequencer and its cause register.
// Assumes core_partner as the core and APB timing as the designer describes it.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module stop_recovery_reset_status_test;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic stopEnter, powerUpEvent, debuggerReset, dogTimeout, dogResetSelect, interruptsOn;
  logic pinResetFiltered_n, debugPin_n, supplyLow, stopRequest;
  logic [7:0] portPins, wakeEnable, portInput, dogControl, wakes, irqs;
  logic coreReset, systemReset, oscEnable, dogIrq, lowSupplyIrq, irqEarly;
  logic [1:0] clockSelect;
  logic [15:0] holdLen, fetchAddr;
  int failCount = 0;
  int checked = 0;
  int cycles = 0;
  int sysRstCount = 0;

  stop_recovery_reset_status dut_u (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .stopEnter, .powerUpEvent, .debuggerReset, .dogTimeout, .dogResetSelect,
    .interruptsOn, .pinResetFiltered_n, .debugPin_n, .supplyLow, .portPins, .wakeEnable,
    .portInput, .coreReset, .systemReset, .oscEnable, .clockSelect, .dogIrq,
    .lowSupplyIrq, .dogControl
  );
  core_partner core_u (
    .core_clk, .sys_rst, .stopRequest, .coreReset, .dogIrq, .stopEnter,
    .holdLen_q(holdLen), .fetchAddr_q(fetchAddr), .wakes_q(wakes), .irqs_q(irqs),
    .irqEarly_q(irqEarly)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (systemReset === 1'b1) sysRstCount++;
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h00000000, rd, err);
    `CHK(rd, exp)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask

  // 0 stop, 1 watchdog time-out, 2 power-up, 3 debugger reset
  task automatic pulse(input int which);
    @(posedge core_clk);
    case (which)
      0: stopRequest <= 1'b1;
      1: dogTimeout <= 1'b1;
      2: powerUpEvent <= 1'b1;
      default: debuggerReset <= 1'b1;
    endcase
    @(posedge core_clk);
    stopRequest <= 1'b0;
    dogTimeout <= 1'b0;
    powerUpEvent <= 1'b0;
    debuggerReset <= 1'b0;
    tick(2);
  endtask

  task automatic waitWake(input int limit);
    int n;
    logic [7:0] w;
    n = 0;
    w = wakes;
    while (wakes === w && n < limit) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(n < limit, 1'b1)
    tick(4);
  endtask

  initial begin
    logic [31:0] rd;
    logic err;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {stopRequest, powerUpEvent, debuggerReset, dogTimeout, supplyLow} = '0;
    dogResetSelect = 1'b1;
    interruptsOn = 1'b1;
    pinResetFiltered_n = 1'b1;
    debugPin_n = 1'b1;
    portPins = 8'h02;
    wakeEnable = 8'h03;
    tick(4);
    sys_rst <= 1'b0;
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000080);
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000000);
    supplyLow <= 1'b1;
    wr(stop_recovery_pkg::ADDR_CAUSE, 32'h0000005A);
    `CHK(dogControl, 8'h5A)
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000001);
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000001);
    wr(stop_recovery_pkg::ADDR_LOWSUP, 32'h00000001);
    tick(3);
    `CHK(lowSupplyIrq, 1'b1)
    wr(stop_recovery_pkg::ADDR_LOWSUP, 32'h00000003);
    tick(3);
    `CHK(lowSupplyIrq, 1'b0)
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000000);
    wr(stop_recovery_pkg::ADDR_LOWSUP, 32'h00000000);
    supplyLow <= 1'b0;
    apb(1'b0, 12'h100, 32'h00000000, rd, err);
    `CHK({err, rd}, 33'h100000000)
    // full resets from stop
    pulse(0);
    pinResetFiltered_n <= 1'b0;
    tick(4);
    pinResetFiltered_n <= 1'b1;
    tick(3);
    `CHK(sysRstCount, 1)
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000010);
    pulse(0);
    debugPin_n <= 1'b0;
    tick(4);
    debugPin_n <= 1'b1;
    tick(3);
    `CHK(sysRstCount, 2)
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000080);
    // pin reset then power-up, leaving only the power-up bit pending, then a pin-change wake
    pulse(0);
    pinResetFiltered_n <= 1'b0;
    tick(4);
    pinResetFiltered_n <= 1'b1;
    tick(3);
    pulse(2);
    wr(stop_recovery_pkg::ADDR_OSC, 32'h00000002);
    wr(stop_recovery_pkg::ADDR_CAUSE, 32'h000000C3);
    `CHK(clockSelect, 2'h2)
    pulse(0);
    portPins <= 8'h82;
    tick(10);
    `CHK(coreReset, 1'b0)
    portPins <= 8'h81;
    tick(2);
    portPins <= 8'h80;
    waitWake(300);
    `CHK(holdLen, 16'(stop_recovery_pkg::HOLD_SHORT_CYC + 1))
    `CHK(fetchAddr, 16'h0002)
    `CHK({oscEnable, clockSelect}, 3'b100)
    `CHK(dogControl, stop_recovery_pkg::DOG_CTL_RESET)
    `CHK(portInput, 8'h80)
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000040);
    // watchdog wake, crystal on, interrupt selected
    wr(stop_recovery_pkg::ADDR_OSC, 32'h00000022);
    dogResetSelect <= 1'b0;
    pulse(0);
    pulse(1);
    waitWake(6000);
    `CHK(holdLen, 16'(stop_recovery_pkg::HOLD_LONG_CYC + 1))
    `CHK(irqs, 8'h01)
    `CHK(irqEarly, 1'b0)
    `CHK(sysRstCount, 3)
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000060);
    // rising pin wake, then a time-out while running
    wr(stop_recovery_pkg::ADDR_OSC, 32'h00000000);
    pulse(0);
    portPins <= 8'h81;
    waitWake(300);
    `CHK(portInput, 8'h81)
    pulse(1);
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000020);
    pulse(3);
    rdChk(stop_recovery_pkg::ADDR_CAUSE, 32'h00000080);
    complete_run();
  end
endmodule
